// [design/prmap_pkg.sv]
// package: offsets, reset values and timing constants of the peripheral register map
package prmap_pkg;
  // ---------------------------------------------------------------
  // register offsets within the 256-byte window
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_A_IN = 8'h00;
  localparam logic [7:0] OFF_B_IN = 8'h01;
  localparam logic [7:0] OFF_C_IN = 8'h10;
  localparam logic [7:0] OFF_D_IN = 8'h11;
  localparam logic [7:0] OFF_E_IN = 8'h30;
  localparam logic [7:0] OFF_F_IN = 8'h40;
  localparam logic [7:0] OFF_G_IN = 8'h41;
  localparam logic [7:0] OFF_E_FUNC = 8'h32;
  localparam logic [7:0] OFF_F_FUNC = 8'h42;
  localparam logic [7:0] OFF_G_FUNC = 8'h43;
  localparam logic [7:0] OFF_A_OUT = 8'h04;
  localparam logic [7:0] OFF_B_OUT = 8'h05;
  localparam logic [7:0] OFF_C_OUT = 8'h14;
  localparam logic [7:0] OFF_D_OUT = 8'h15;
  localparam logic [7:0] OFF_E_OUT = 8'h34;
  localparam logic [7:0] OFF_F_OUT = 8'h44;
  localparam logic [7:0] OFF_G_OUT = 8'h45;
  localparam logic [7:0] OFF_A_DIR = 8'h06;
  localparam logic [7:0] OFF_B_DIR = 8'h07;
  localparam logic [7:0] OFF_C_DIR = 8'h16;
  localparam logic [7:0] OFF_D_DIR = 8'h17;
  localparam logic [7:0] OFF_E_DIR = 8'h36;
  localparam logic [7:0] OFF_F_DIR = 8'h46;
  localparam logic [7:0] OFF_G_DIR = 8'h47;
  localparam logic [7:0] OFF_A_DRV = 8'h08;
  localparam logic [7:0] OFF_B_DRV = 8'h09;
  localparam logic [7:0] OFF_C_DRV = 8'h18;
  localparam logic [7:0] OFF_D_DRV = 8'h19;
  localparam logic [7:0] OFF_E_DRV = 8'h38;
  localparam logic [7:0] OFF_F_DRV = 8'h48;
  localparam logic [7:0] OFF_G_DRV = 8'h49;
  localparam logic [7:0] OFF_A_IMC = 8'h0A;
  localparam logic [7:0] OFF_B_IMC = 8'h0B;
  localparam logic [7:0] OFF_D_IMC = 8'h1A;
  localparam logic [7:0] OFF_A_OEN = 8'h0C;
  localparam logic [7:0] OFF_B_OEN = 8'h0D;
  localparam logic [7:0] OFF_C_OEN = 8'h1C;
  localparam logic [7:0] OFF_F_OEN = 8'h4C;
  localparam logic [7:0] OFF_CELL_A = 8'h20;
  localparam logic [7:0] OFF_CELL_B = 8'h21;
  localparam logic [7:0] OFF_BLK_A = 8'h22;
  localparam logic [7:0] OFF_BLK_B = 8'h23;
  localparam logic [7:0] OFF_PWR_FIRST = 8'hB0;
  localparam logic [7:0] OFF_PWR_SECOND = 8'hB4;
  localparam logic [7:0] OFF_PRI_LOCK = 8'hC0;
  localparam logic [7:0] OFF_SEC_LOCK = 8'hC2;
  localparam logic [7:0] OFF_TEST_PORT = 8'hC7;
  localparam logic [7:0] OFF_PAGE = 8'hE0;
  localparam logic [7:0] OFF_SPACE = 8'hE2;
  localparam logic [7:0] OFF_MEM_ID0 = 8'hF0;
  localparam logic [7:0] OFF_MEM_ID1 = 8'hF1;
  // ---------------------------------------------------------------
  // field positions, reset and fill values
  // ---------------------------------------------------------------
  localparam int FAST_BIT = 3;
  localparam int PDOWN_EN_BIT = 1;
  localparam int TEST_ON_BIT = 0;
  localparam int SECURITY_BIT = 7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PWR_FIRST = 8'h08;
  localparam logic [7:0] RST_SPACE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hFF;
  // ---------------------------------------------------------------
  // idle time before automatic power-down
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PDOWN_IDLE_US = 100;
  localparam int PDOWN_IDLE_CYCLES = (PDOWN_IDLE_US * (CLK_HZ / 1_000_000));
endpackage : prmap_pkg

// [design/prmap_top.sv]
// module: register window, port registers, logic cell load/mask and power control
// Function
// - registers sit at fixed offsets in a 256-byte window placed at a configured base
// - fast bit at 0 holds the gated logic array inputs until those inputs change
// - second power register bits block matching inputs into the logic array
// - automatic power-down turns functions off while the host is idle
// - pin level registers at 00,01,10,11,30,40,41 return live pins
// - pin function registers at 32,42,43 choose host i/o or address output
// - output latches at 04,05,14,15,34,44,45 drive pins in output mode
// - driver type registers at 08..49 choose open drain or slew rate
// - read-only driver-on status at 0C,0D,1C,4C shows enabled drivers
// - cell registers at 20,21 read cell outputs and load cell flip-flops
// - write block registers at 22,23 stop host loads of chosen cells
// - read-only C0 reports primary flash sector locks
// - read-only C2 reports security state and secondary sector locks
// - B0 holds the fast bit and other power settings
// - read-only F0 and F1 report memory sizes and type
// - host code may alter flash only, never logic arrays or configuration
// - C7 bit 0 enables the serial test port on port e
// - page register at E0 is 8 bits and feeds the address decode
//
// Added by the designer: strobed register access.
module prmap_top #(
  parameter int ADDR_W = 16,
  parameter int PDOWN_IDLE = prmap_pkg::PDOWN_IDLE_CYCLES,
  parameter logic [7:0] MEM_ID0_VALUE = 8'h00, // arbitrary value
  parameter logic [7:0] MEM_ID1_VALUE = 8'h00  // arbitrary value
) (
  input wire logic clk, // 20 mhz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [ADDR_W-1:0] window_base, // configured window base
  input wire logic [ADDR_W-1:0] bus_addr, // host address
  input wire logic [7:0] bus_wdata, // host write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [7:0] bus_rdata, // read data, cycle after read
  input wire logic [55:0] pin_in, // pin levels, ports a..g
  input wire logic [23:0] imc_in, // input cells a,b,d
  input wire logic [55:0] pin_oe_in, // live driver enables a..g
  input wire logic [15:0] cell_in, // logic array cell outputs
  input wire logic [7:0] pri_lock_in, // primary sector locks
  input wire logic [3:0] sec_lock_in, // secondary sector locks
  input wire logic security_in, // security state
  input wire logic [55:0] array_in, // logic array input signals
  output logic [55:0] pin_out, // output latch values
  output logic [55:0] pin_dir, // pin directions
  output logic [55:0] pin_drv, // driver type select
  output logic [23:0] pin_func, // port e,f,g pin function
  output logic [15:0] cell_load, // cell flip-flop load value
  output logic [15:0] cell_load_en, // per-cell load pulse
  output logic [55:0] array_gated, // inputs passed to logic array
  output logic array_standby, // logic array in standby
  output logic power_down, // automatic power-down active
  output logic test_port_on, // serial test port enable
  output logic [7:0] page_value_bits, // page value to decode
  output logic [7:0] memory_space_placement, // space placement bits
  output logic [7:0] power_control_first, // first power register
  output logic [7:0] power_control_second // second power register
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic [55:0] out_latch;
    logic [55:0] dir;
    logic [55:0] drv;
    logic [23:0] func;
    logic [15:0] blk;
    logic [15:0] load;
    logic [15:0] load_en;
    logic [7:0] pwr1;
    logic [7:0] pwr2;
    logic [7:0] test;
    logic [7:0] page;
    logic [7:0] space;
    logic [55:0] gated;
    logic [55:0] last_in;
    logic standby;
    logic [31:0] idle;
    logic pdown;
  } prmap_state_t;

  prmap_state_t st;
  prmap_state_t next_st;
  logic in_win;
  logic [7:0] off;
  logic [55:0] next_gate;

  // refuse widths and idle counts the logic cannot serve; window compare needs bit 8
  if (ADDR_W < 9 || ADDR_W > 32 || PDOWN_IDLE < 1) begin : g_bad_params
    $error("prmap_top: unsupported parameter values");
  end

  // port index for a given offset base, -1 when none
  function automatic int port_of(input logic [7:0] o, input logic [7:0] ofs [7]);
    int p;
    p = -1;
    for (int i = 0; i < 7; i++) begin
      if (o == ofs[i]) begin
        p = i;
      end
    end
    return p;
  endfunction

  localparam logic [7:0] IN_OFS [7] = '{prmap_pkg::OFF_A_IN, prmap_pkg::OFF_B_IN, prmap_pkg::OFF_C_IN,
    prmap_pkg::OFF_D_IN, prmap_pkg::OFF_E_IN, prmap_pkg::OFF_F_IN, prmap_pkg::OFF_G_IN};
  localparam logic [7:0] OUT_OFS [7] = '{prmap_pkg::OFF_A_OUT, prmap_pkg::OFF_B_OUT, prmap_pkg::OFF_C_OUT,
    prmap_pkg::OFF_D_OUT, prmap_pkg::OFF_E_OUT, prmap_pkg::OFF_F_OUT, prmap_pkg::OFF_G_OUT};
  localparam logic [7:0] DIR_OFS [7] = '{prmap_pkg::OFF_A_DIR, prmap_pkg::OFF_B_DIR, prmap_pkg::OFF_C_DIR,
    prmap_pkg::OFF_D_DIR, prmap_pkg::OFF_E_DIR, prmap_pkg::OFF_F_DIR, prmap_pkg::OFF_G_DIR};
  localparam logic [7:0] DRV_OFS [7] = '{prmap_pkg::OFF_A_DRV, prmap_pkg::OFF_B_DRV, prmap_pkg::OFF_C_DRV,
    prmap_pkg::OFF_D_DRV, prmap_pkg::OFF_E_DRV, prmap_pkg::OFF_F_DRV, prmap_pkg::OFF_G_DRV};

  // ---------------------------------------------------------------
  // window decode
  // ---------------------------------------------------------------
  assign in_win = (bus_addr[ADDR_W-1:8] == window_base[ADDR_W-1:8]);
  assign off = bus_addr[7:0];

  // inputs blocked per bit of the second power register, one byte lane each
  always_comb begin
    next_gate = '0;
    for (int p = 0; p < 7; p++) begin
      next_gate[p*8 +: 8] = array_in[p*8 +: 8] & ~{8{st.pwr2[p]}};
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    int pi;
    int po;
    int pd;
    int pv;
    logic hit_wr;
    logic hit_rd;
    logic [15:0] sel;
    pi = port_of(off, IN_OFS);
    po = port_of(off, OUT_OFS);
    pd = port_of(off, DIR_OFS);
    pv = port_of(off, DRV_OFS);
    hit_wr = bus_wr && in_win;
    hit_rd = bus_rd && in_win;
    sel = '0;
    next_st = st;
    next_st.load_en = '0;
    next_st.rdata = prmap_pkg::RST_ZERO;
    // host writes; read-only offsets fall through untouched
    if (hit_wr) begin
      if (po >= 0) next_st.out_latch[po*8 +: 8] = bus_wdata;
      if (pd >= 0) next_st.dir[pd*8 +: 8] = bus_wdata;
      if (pv >= 0) next_st.drv[pv*8 +: 8] = bus_wdata;
      unique case (off)
        prmap_pkg::OFF_E_FUNC: next_st.func[7:0] = bus_wdata;
        prmap_pkg::OFF_F_FUNC: next_st.func[15:8] = bus_wdata;
        prmap_pkg::OFF_G_FUNC: next_st.func[23:16] = bus_wdata;
        prmap_pkg::OFF_BLK_A: next_st.blk[7:0] = bus_wdata;
        prmap_pkg::OFF_BLK_B: next_st.blk[15:8] = bus_wdata;
        prmap_pkg::OFF_CELL_A: sel[7:0] = 8'hFF;
        prmap_pkg::OFF_CELL_B: sel[15:8] = 8'hFF;
        prmap_pkg::OFF_PWR_FIRST: next_st.pwr1 = bus_wdata;
        prmap_pkg::OFF_PWR_SECOND: next_st.pwr2 = bus_wdata;
        prmap_pkg::OFF_TEST_PORT: next_st.test = {7'h00, bus_wdata[prmap_pkg::TEST_ON_BIT]};
        prmap_pkg::OFF_PAGE: next_st.page = bus_wdata;
        prmap_pkg::OFF_SPACE: next_st.space = bus_wdata;
        default: ;
      endcase
      // cell loads pass only where the write block bit is clear
      next_st.load = {bus_wdata, bus_wdata};
      next_st.load_en = sel & ~st.blk;
    end
    // host reads: data appear one cycle later
    if (hit_rd) begin
      next_st.rdata = prmap_pkg::UNMAPPED_VALUE;
      if (pi >= 0) next_st.rdata = pin_in[pi*8 +: 8];
      if (po >= 0) next_st.rdata = st.out_latch[po*8 +: 8];
      if (pd >= 0) next_st.rdata = st.dir[pd*8 +: 8];
      if (pv >= 0) next_st.rdata = st.drv[pv*8 +: 8];
      unique case (off)
        prmap_pkg::OFF_E_FUNC: next_st.rdata = st.func[7:0];
        prmap_pkg::OFF_F_FUNC: next_st.rdata = st.func[15:8];
        prmap_pkg::OFF_G_FUNC: next_st.rdata = st.func[23:16];
        prmap_pkg::OFF_A_IMC: next_st.rdata = imc_in[7:0];
        prmap_pkg::OFF_B_IMC: next_st.rdata = imc_in[15:8];
        prmap_pkg::OFF_D_IMC: next_st.rdata = imc_in[23:16];
        prmap_pkg::OFF_A_OEN: next_st.rdata = pin_oe_in[7:0];
        prmap_pkg::OFF_B_OEN: next_st.rdata = pin_oe_in[15:8];
        prmap_pkg::OFF_C_OEN: next_st.rdata = pin_oe_in[23:16];
        prmap_pkg::OFF_F_OEN: next_st.rdata = pin_oe_in[47:40];
        prmap_pkg::OFF_CELL_A: next_st.rdata = cell_in[7:0];
        prmap_pkg::OFF_CELL_B: next_st.rdata = cell_in[15:8];
        prmap_pkg::OFF_BLK_A: next_st.rdata = st.blk[7:0];
        prmap_pkg::OFF_BLK_B: next_st.rdata = st.blk[15:8];
        prmap_pkg::OFF_PWR_FIRST: next_st.rdata = st.pwr1;
        prmap_pkg::OFF_PWR_SECOND: next_st.rdata = st.pwr2;
        prmap_pkg::OFF_PRI_LOCK: next_st.rdata = pri_lock_in;
        prmap_pkg::OFF_SEC_LOCK: next_st.rdata = {security_in, 3'h0, sec_lock_in};
        prmap_pkg::OFF_TEST_PORT: next_st.rdata = st.test;
        prmap_pkg::OFF_PAGE: next_st.rdata = st.page;
        prmap_pkg::OFF_SPACE: next_st.rdata = st.space;
        prmap_pkg::OFF_MEM_ID0: next_st.rdata = MEM_ID0_VALUE;
        prmap_pkg::OFF_MEM_ID1: next_st.rdata = MEM_ID1_VALUE;
        default: ;
      endcase
    end
    // standby: outputs held while fast bit is 0, until an input moves
    next_st.last_in = next_gate;
    if (st.pwr1[prmap_pkg::FAST_BIT]) begin
      next_st.standby = 1'b0;
      next_st.gated = next_gate;
    end else if (next_gate != st.last_in) begin
      next_st.standby = 1'b0;
      next_st.gated = next_gate;
    end else begin
      next_st.standby = 1'b1;
    end
    // automatic power-down after host idle time when enabled
    if (bus_wr || bus_rd || !st.pwr1[prmap_pkg::PDOWN_EN_BIT]) begin
      next_st.idle = '0;
      next_st.pdown = 1'b0;
    end else if (st.idle >= 32'(PDOWN_IDLE - 1)) begin
      next_st.pdown = 1'b1;
    end else begin
      next_st.idle = st.idle + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // state register; no path lets host code reprogram array or config
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.pwr1 <= prmap_pkg::RST_PWR_FIRST;
      st.space <= prmap_pkg::RST_SPACE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign bus_rdata = st.rdata;
  assign pin_out = st.out_latch;
  assign pin_dir = st.dir;
  assign pin_drv = st.drv;
  assign pin_func = st.func;
  assign cell_load = st.load;
  assign cell_load_en = st.load_en;
  assign array_gated = st.gated;
  assign array_standby = st.standby;
  assign power_down = st.pdown;
  assign test_port_on = st.test[prmap_pkg::TEST_ON_BIT];
  assign page_value_bits = st.page;
  assign memory_space_placement = st.space;
  assign power_control_first = st.pwr1;
  assign power_control_second = st.pwr2;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_window_outside_ignored: assert property ((bus_wr && !in_win)
    |=> $stable(st.pwr2) && $stable(st.page) && $stable(st.out_latch))
    else $error("write outside window changed a register");
  a_standby_holds_outputs: assert property (array_standby && $past(array_standby) |-> $stable(array_gated))
    else $error("gated inputs moved in standby");
  a_fast_no_standby: assert property (power_control_first[prmap_pkg::FAST_BIT] |=> !array_standby)
    else $error("standby while fast bit set");
  a_block_input_low: assert property (power_control_second[0] |=> array_gated[7:0] == 8'h00 || array_standby)
    else $error("blocked input reached logic array");
  a_pdown_clears_on_access: assert property ((bus_rd || bus_wr) |=> !power_down)
    else $error("power-down stayed on host access");
  a_pin_read_live: assert property ((bus_rd && in_win && off == prmap_pkg::OFF_A_IN)
    |=> bus_rdata == $past(pin_in[7:0]))
    else $error("port a pin read wrong");
  a_func_write_g: assert property ((bus_wr && in_win && off == prmap_pkg::OFF_G_FUNC)
    |=> pin_func[23:16] == $past(bus_wdata))
    else $error("port g function not written");
  a_latch_write_e: assert property ((bus_wr && in_win && off == prmap_pkg::OFF_E_OUT)
    |=> pin_out[39:32] == $past(bus_wdata))
    else $error("port e latch not written");
  a_dir_write_f: assert property ((bus_wr && in_win && off == prmap_pkg::OFF_F_DIR)
    |=> pin_dir[47:40] == $past(bus_wdata))
    else $error("port f direction not written");
  a_cell_load_masked: assert property ((bus_wr && in_win && off == prmap_pkg::OFF_CELL_A)
    |=> cell_load_en[7:0] == ~$past(st.blk[7:0]))
    else $error("cell load ignored write block");
  a_sec_lock_read: assert property ((bus_rd && in_win && off == prmap_pkg::OFF_SEC_LOCK)
    |=> bus_rdata[6:4] == 3'h0)
    else $error("unused secondary lock bits not zero");
  a_test_port_bit: assert property ((bus_wr && in_win && off == prmap_pkg::OFF_TEST_PORT)
    |=> test_port_on == $past(bus_wdata[0]))
    else $error("test port enable wrong");
  a_unmapped_read: assert property ((bus_rd && in_win && off == 8'hFF)
    |=> bus_rdata == prmap_pkg::UNMAPPED_VALUE)
    else $error("unmapped read not defined");

  c_cell_write: cover property (bus_wr && in_win && off == prmap_pkg::OFF_CELL_B);
  c_standby_entered: cover property (!array_standby ##1 array_standby);
  c_power_down: cover property (!power_down ##1 power_down);
  c_page_write: cover property (bus_wr && in_win && off == prmap_pkg::OFF_PAGE);
endmodule // prmap_top

// [tb/prmap_host.sv]
// host bus master model for the register port
module prmap_host (
  input wire logic clk, // bus clock
  output logic [15:0] bus_addr, // byte address
  output logic [7:0] bus_wdata, // write data
  output logic bus_wr, // write strobe
  output logic bus_rd // read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // one write cycle; lines scrambled once released
  task automatic write_cycle(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  // one read cycle; data is taken by the bench one cycle later
  task automatic read_cycle(input logic [15:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
  endtask
endmodule // prmap_host

// [tb/tb_prmap_top.sv]
// self-checking bench for the peripheral register map
module tb_prmap_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] BASE = 16'h4A00;
  localparam int IDLE = 8;
  localparam logic [7:0] ID0 = 8'h3C; // arbitrary value
  localparam logic [7:0] ID1 = 8'hC3; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, page_value_bits, memory_space_placement;
  logic [7:0] power_control_first, power_control_second, pri_lock_in = 8'h00, m, d;
  logic bus_wr, bus_rd, array_standby, power_down, test_port_on, security_in = 1'b0;
  logic [55:0] pin_in = '0, pin_oe_in = '0, array_in = '0, pin_out, pin_dir, pin_drv, array_gated, v;
  logic [23:0] imc_in = '0, pin_func;
  logic [15:0] cell_in = '0, cell_load, cell_load_en;
  logic [3:0] sec_lock_in = 4'h0;
  int mismatches = 0;
  int check_count = 0;
  integer seed = 72;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] wv [29];
  logic [7:0] rw_tab [29] = '{8'h04, 8'h05, 8'h14, 8'h15, 8'h34, 8'h44, 8'h45, 8'h06, 8'h07, 8'h16, 8'h17,
    8'h36, 8'h46, 8'h47, 8'h08, 8'h09, 8'h18, 8'h19, 8'h38, 8'h48, 8'h49, 8'h32, 8'h42, 8'h43, 8'h22, 8'h23,
    8'hB4, 8'hE0, 8'hE2};
  logic [7:0] ro_off [18] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40, 8'h41, 8'h0A, 8'h0B, 8'h1A, 8'h0C,
    8'h0D, 8'h1C, 8'h4C, 8'hC0, 8'hC2, 8'hF0, 8'hF1};
  // clock
  always #25 clk = ~clk;
  prmap_host host_u (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));
  prmap_top #(.ADDR_W(16), .PDOWN_IDLE(IDLE), .MEM_ID0_VALUE(ID0), .MEM_ID1_VALUE(ID1)) dut_u (
    .clk(clk), .rst_n(rst_n), .window_base(BASE), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_in(pin_in), .imc_in(imc_in),
    .pin_oe_in(pin_oe_in), .cell_in(cell_in), .pri_lock_in(pri_lock_in), .sec_lock_in(sec_lock_in),
    .security_in(security_in), .array_in(array_in), .pin_out(pin_out), .pin_dir(pin_dir), .pin_drv(pin_drv),
    .pin_func(pin_func), .cell_load(cell_load), .cell_load_en(cell_load_en), .array_gated(array_gated),
    .array_standby(array_standby), .power_down(power_down), .test_port_on(test_port_on),
    .page_value_bits(page_value_bits), .memory_space_placement(memory_space_placement),
    .power_control_first(power_control_first), .power_control_second(power_control_second));
  // compare one value, count and report
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] dat);
    host_u.write_cycle({BASE[15:8], off}, dat);
  endtask
  // note the expected read data, then issue the read
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.read_cycle({BASE[15:8], off});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // read data watcher: oldest note against the cycle after each read
  always @(posedge clk) begin
    if (rd_pend) begin
      check("bus_rdata", bus_rdata, exp_q.pop_front());
    end
    rd_pend <= bus_rd;
  end
  // watchdog
  initial begin
    #(50 * 20000);
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pin_in <= 56'({$random(seed), $random(seed)});
    pin_oe_in <= 56'({$random(seed), $random(seed)});
    array_in <= 56'({$random(seed), $random(seed)});
    imc_in <= 24'($random(seed));
    cell_in <= 16'($random(seed));
    pri_lock_in <= 8'($random(seed));
    sec_lock_in <= 4'($random(seed));
    security_in <= 1'b1;
    #1;
    check("power_control_first", power_control_first, 8'h08);
    check("pin_dir", pin_dir, 56'h0);
    // read/write registers: reset value, then random readback
    for (int i = 0; i < 29; i++) begin
      rd(rw_tab[i], 8'h00);
      wv[i] = 8'($random(seed));
      wr(rw_tab[i], wv[i]);
      rd(rw_tab[i], wv[i]);
    end
    rd(8'hB0, 8'h08);
    check("pin_out", pin_out, {wv[6], wv[5], wv[4], wv[3], wv[2], wv[1], wv[0]});
    check("pin_dir", pin_dir, {wv[13], wv[12], wv[11], wv[10], wv[9], wv[8], wv[7]});
    check("pin_drv", pin_drv, {wv[20], wv[19], wv[18], wv[17], wv[16], wv[15], wv[14]});
    check("pin_func", pin_func, {wv[23], wv[22], wv[21]});
    check("power_control_second", power_control_second, wv[26]);
    check("page_value_bits", page_value_bits, wv[27]);
    check("memory_space_placement", memory_space_placement, wv[28]);
    $display("test rw_registers done");
    // outside the window nothing answers; unmapped reads give the fill value
    host_u.write_cycle(16'h1204, ~wv[0]);
    exp_q.push_back(8'h00);
    host_u.read_cycle(16'h1204);
    rd(8'h04, wv[0]);
    rd(8'h50, 8'hFF);
    rd(8'hFF, 8'hFF);
    // read-only registers ignore writes and show live inputs, or the fixed ids at F0 and F1
    for (int i = 0; i < 18; i++) begin
      wr(ro_off[i], 8'hA5);
    end
    for (int p = 0; p < 7; p++) begin
      rd(ro_off[p], pin_in[8*p +: 8]);
    end
    for (int p = 0; p < 3; p++) begin
      rd(ro_off[7+p], imc_in[8*p +: 8]);
    end
    rd(8'h0C, pin_oe_in[7:0]);
    rd(8'h0D, pin_oe_in[15:8]);
    rd(8'h1C, pin_oe_in[23:16]);
    rd(8'h4C, pin_oe_in[47:40]);
    rd(8'hC0, pri_lock_in);
    rd(8'hC2, {security_in, 3'b000, sec_lock_in});
    rd(8'hF0, ID0);
    rd(8'hF1, ID1);
    $display("test read_only done");
    // test port enable keeps bit 0 only
    wr(8'hC7, 8'hFF);
    #1;
    check("test_port_on", test_port_on, 1'b1);
    rd(8'hC7, 8'h01);
    wr(8'hC7, 8'hFE);
    #1;
    check("test_port_on", test_port_on, 1'b0);
    $display("test test_port done");
    // cell loads, with the write block masking chosen cells
    for (int g = 0; g < 2; g++) begin
      m = 8'($random(seed));
      d = 8'($random(seed));
      wr(8'(8'h22 + g), m);
      wr(8'(8'h20 + g), d);
      #1;
      check("cell_load", cell_load[8*g +: 8], d);
      check("cell_load_en", cell_load_en, {8'h00, ~m} << (8 * g));
      @(posedge clk);
      #1;
      check("cell_load_en", cell_load_en, 16'h0000);
      rd(8'(8'h20 + g), cell_in[8*g +: 8]);
    end
    $display("test cell_load done");
    // input blocking in fast mode, then standby with fast bit cleared
    wr(8'hB4, 8'h01);
    array_in <= 56'({$random(seed), $random(seed)});
    repeat (3) @(posedge clk);
    #1;
    check("array_gated", array_gated, {array_in[55:8], 8'h00});
    check("array_standby", array_standby, 1'b0);
    wr(8'hB0, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    check("array_standby", array_standby, 1'b1);
    v = array_in ^ 56'h00_0000_0000_FF00;
    @(posedge clk);
    array_in <= v;
    @(posedge clk);
    #1;
    check("array_standby", array_standby, 1'b0);
    check("array_gated", array_gated, {v[55:8], 8'h00});
    @(posedge clk);
    #1;
    check("array_standby", array_standby, 1'b1);
    $display("test power_array done");
    // automatic power-down after idle, cleared by a strobe
    wr(8'hB0, 8'h0A);
    repeat (IDLE - 1) @(posedge clk);
    #1;
    check("power_down", power_down, 1'b0);
    @(posedge clk);
    #1;
    check("power_down", power_down, 1'b1);
    rd(8'hB0, 8'h0A);
    @(posedge clk);
    #1;
    check("power_down", power_down, 1'b0);
    $display("test power_down done");
    repeat (4) @(posedge clk);
    results();
  end
endmodule // tb_prmap_top
